// >>> hw/fpu_exception_unit.v
// exception detection, status/control words and output gating
// Functional notes
// - six exceptions, fixed precedence invalid first
// - unmasked exception sets flag, summary, fault
// - capture instruction and operand addresses
// - no-wait init command clears fault output
// - reset sets invalid and summary, unmasks invalid
// - control bit 12 reserved, cleared, writable
// - condition codes zeroed: reset, init, partial remainder
// - masked invalid gives indefinite; stack fault flagged
// - denormal: minimum exponent, nonzero significand
// - zero divide: zero divisor, finite nonzero dividend
// - masked overflow result follows rounding mode
// - masked underflow flagged only on accuracy loss
// - inexact raised when rounding was needed
// - split exponent of zero: zero divide
// - signaling NaN invalid; quiet only some ops
// - short load of denormal or signaling NaN
// - extended load never raises denormal
// - bogus non-empty tag writes ignored
// - pseudo and unnormal encodings are invalid
// - data bus floats unless enabled and selected; fault pin floats unless enabled
// - control bits 5..0 mask six exceptions
//
// Local design decisions: the plain strobed port and the register offsets.
`include "fpu_exc_regs.vh"
module fpu_exception_unit #(
	parameter ADDR_W = 32
) (
	// clock and reset
	input wire sys_clk,
	input wire rst_b,
	// register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// operation event from the datapath
	input wire op_done,
	input wire op_sig_nan,
	input wire op_quiet_nan,
	input wire op_qnan_traps,
	input wire op_unsupported,
	input wire op_indeterminate,
	input wire op_stack_fault,
	input wire op_min_exp,
	input wire op_sig_nonzero,
	input wire op_ext_load,
	input wire op_divide,
	input wire op_divisor_zero,
	input wire op_dividend_finite_nz,
	input wire op_split_exp_zero,
	input wire op_overflow,
	input wire op_tiny,
	input wire op_acc_loss,
	input wire op_not_exact,
	input wire [ADDR_W-1:0] op_ip,
	input wire [ADDR_W-1:0] op_dp,
	input wire op_has_mem,
	// masked default result selection
	output reg [2:0] default_result,
	output reg round_to_inf,
	output reg stall_result,
	// pins, synchronised
	input wire output_status_enable,
	input wire coproc_select_low_n,
	input wire coproc_select_high,
	input wire bus_read,
	input wire [31:0] data_out_val,
	output wire [31:0] data_bus_pins_o,
	output wire data_bus_pins_oe,
	output wire fault_signal_n_o,
	output wire fault_signal_n_oe
);
	localparam RES_NONE = 3'h0;
	localparam RES_QNAN = 3'h1;
	localparam RES_INF = 3'h2;
	localparam RES_MAXINF = 3'h3;
	localparam RES_DENZ = 3'h4;
	localparam RES_NEGINF_NEXT = 3'h5;
	reg [15:0] ctrl_r;
	reg [5:0] flags_r;
	reg sf_r;
	reg es_r;
	reg [3:0] cc_r;
	reg [15:0] tag_r;
	reg [15:0] tag_actual_r;
	reg [ADDR_W-1:0] ip_r;
	reg [ADDR_W-1:0] dp_r;
	reg [5:0] last_exc_r;
	reg [2:0] output_status_enable_s;
	reg [2:0] sel_lo_s;
	reg [2:0] sel_hi_s;
	reg [2:0] rd_s;
	reg [1:0] output_status_enable_sync_r;
	reg [1:0] sel_lo_sync_r;
	reg [1:0] sel_hi_sync_r;
	reg [1:0] rd_sync_r;
	reg [31:0] dout_r;
	reg [5:0] exc;
	reg [5:0] hit;
	reg inv_nan;
	integer i;
	// separate index so the tag loop and the precedence loop share no driver
	integer j;
	wire cmd_wr = reg_wr && (reg_addr == `ADDR_CMD);
	wire [3:0] cmd = reg_wdata[3:0];
	wire do_init = cmd_wr && (cmd == `CMD_INIT);
	wire do_clex = cmd_wr && (cmd == `CMD_CLEX);
	wire do_ldcw = cmd_wr && (cmd == `CMD_LDCW);
	wire do_ldtag = cmd_wr && (cmd == `CMD_LDTAG);
	wire do_prem = cmd_wr && (cmd == `CMD_PREM_INC);
	wire [5:0] mask = ctrl_r[5:0];
	// detection of raw conditions
	always @* begin
		inv_nan = op_sig_nan || (op_quiet_nan && op_qnan_traps);
		exc = 6'h00;
		exc[`EXC_INV] = inv_nan || op_unsupported ||
			op_indeterminate || op_stack_fault;
		exc[`EXC_DEN] = op_min_exp && op_sig_nonzero && !op_ext_load;
		exc[`EXC_ZDV] = (op_divide && op_divisor_zero &&
			op_dividend_finite_nz) || op_split_exp_zero;
		exc[`EXC_OVF] = op_overflow;
		exc[`EXC_UNF] = op_tiny && (!mask[`EXC_UNF] || op_acc_loss);
		exc[`EXC_PRE] = op_not_exact;
		// precedence: first unmasked exception stops the rest
		hit = 6'h00;
		for (i = 0; i < 6; i = i + 1) begin
			if (exc[i] && (hit & ~mask) == 6'h00)
				hit[i] = 1'b1;
		end
	end
	// masked default result
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			default_result <= RES_NONE;
			round_to_inf <= 1'b0;
			stall_result <= 1'b0;
		end else begin
			stall_result <= op_done && ((hit & ~mask) != 6'h00);
			round_to_inf <= 1'b0;
			default_result <= RES_NONE;
			if (op_done) begin
				if (hit[`EXC_INV])
					default_result <= RES_QNAN;
				else if (op_split_exp_zero)
					default_result <= RES_NEGINF_NEXT;
				else if (hit[`EXC_ZDV])
					default_result <= RES_INF;
				else if (hit[`EXC_OVF]) begin
					default_result <= RES_MAXINF;
					round_to_inf <= ctrl_r[11:10] == 2'h0 ||
						(ctrl_r[11:10] != 2'h3 && ctrl_r[10] != ctrl_r[11]);
				end else if (hit[`EXC_UNF])
					default_result <= RES_DENZ;
			end
		end
	end
	// pin synchronisers
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			output_status_enable_sync_r <= 2'h0;
			sel_lo_sync_r <= 2'h3;
			sel_hi_sync_r <= 2'h0;
			rd_sync_r <= 2'h0;
		end else begin
			output_status_enable_sync_r <= {output_status_enable_sync_r[0], output_status_enable};
			sel_lo_sync_r <= {sel_lo_sync_r[0], coproc_select_low_n};
			sel_hi_sync_r <= {sel_hi_sync_r[0], coproc_select_high};
			rd_sync_r <= {rd_sync_r[0], bus_read};
		end
	end
	wire output_status_enable_q = output_status_enable_sync_r[1];
	wire sel_q = !sel_lo_sync_r[1] && sel_hi_sync_r[1];
	assign fault_signal_n_o = !es_r;
	assign fault_signal_n_oe = output_status_enable_q;
	assign data_bus_pins_oe = output_status_enable_q && sel_q && rd_sync_r[1];
	assign data_bus_pins_o = dout_r;
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			dout_r <= 32'h00000000;
		else
			dout_r <= data_out_val;
	end
	// status, control, tags and pointers
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= `CW_RESET_VAL;
			flags_r <= 6'h01;
			es_r <= 1'b1;
			sf_r <= 1'b0;
			cc_r <= 4'h0;
			tag_r <= 16'hFFFF;
			tag_actual_r <= 16'hFFFF;
			ip_r <= {ADDR_W{1'b0}};
			dp_r <= {ADDR_W{1'b0}};
			last_exc_r <= 6'h00;
		end else begin
			if (reg_wr && reg_addr == `ADDR_TAG)
				tag_actual_r <= reg_wdata[15:0];
			if (do_init) begin
				ctrl_r <= `CW_INIT_VAL;
				cc_r <= 4'h0;
				tag_r <= 16'hFFFF;
			end else if (do_ldcw)
				ctrl_r <= reg_wdata[15:0] & `CW_WMASK;
			if (do_prem)
				cc_r <= 4'h0;
			if (do_ldtag) begin
				for (j = 0; j < 8; j = j + 1) begin
					if (reg_wdata[16+2*j +: 2] == `TAG_EMPTY ||
						reg_wdata[16+2*j +: 2] == tag_actual_r[2*j +: 2])
						tag_r[2*j +: 2] <= reg_wdata[16+2*j +: 2];
				end
			end
			// event set wins over clear in the same cycle
			if (op_done) begin
				flags_r <= ((do_init || do_clex) ? 6'h00 : flags_r) |
					hit;
				es_r <= (!(do_init || do_clex) && es_r) ||
					((hit & ~mask) != 6'h00);
				sf_r <= (!(do_init || do_clex) && sf_r) ||
					(hit[`EXC_INV] && op_stack_fault);
				last_exc_r <= hit;
				if (hit != 6'h00) begin
					ip_r <= op_ip;
					if (op_has_mem)
						dp_r <= op_dp;
				end
			end else if (do_init || do_clex) begin
				flags_r <= 6'h00;
				es_r <= 1'b0;
				sf_r <= 1'b0;
			end
		end
	end
	// register read data, one cycle later
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			reg_rdata <= 32'h00000000;
		else if (reg_rd) begin
			case (reg_addr)
			`ADDR_CTRL: reg_rdata <= {16'h0000, ctrl_r};
			`ADDR_STATUS: reg_rdata <= {16'h0000, 1'b0, cc_r[3], 3'h0,
				cc_r[2:0], es_r, sf_r, flags_r};
			`ADDR_TAG: reg_rdata <= {16'h0000, tag_r};
			`ADDR_IPTR: reg_rdata <= ip_r;
			`ADDR_OPTR: reg_rdata <= dp_r;
			`ADDR_EVENT: reg_rdata <= {26'h0000000, last_exc_r};
			default: reg_rdata <= 32'h00000000;
			endcase
		end else
			reg_rdata <= 32'h00000000;
	end
endmodule // fpu_exception_unit

// >>> hw/fpu_exc_regs.vh
// register offsets, field positions and reset values of the exception unit
`ifndef FPU_EXC_REGS_VH
`define FPU_EXC_REGS_VH
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_TAG 4'h2
`define ADDR_IPTR 4'h3
`define ADDR_OPTR 4'h4
`define ADDR_CMD 4'h5
`define ADDR_EVENT 4'h6
`define ADDR_RDATA 4'h7
`define CMD_INIT 4'h1
`define CMD_CLEX 4'h2
`define CMD_LDCW 4'h3
`define CMD_LDTAG 4'h4
`define CMD_PREM_INC 4'h5
`define ST_SF 6
`define ST_ES 7
`define ST_CC0 8
`define ST_CC2 10
`define ST_CC1 9
`define ST_CC3 14
`define CW_RSV12 12
`define CW_INIT_VAL 16'h037F
`define CW_RESET_VAL 16'h037E
`define CW_WMASK 16'h1F3F
`define EXC_INV 0
`define EXC_DEN 1
`define EXC_ZDV 2
`define EXC_OVF 3
`define EXC_UNF 4
`define EXC_PRE 5
`define TAG_EMPTY 2'h3
`define ZERO_DIV_VAL 1'b1
`endif

// >>> verif/fpu_exc_chk.sv
// port checker for the exception unit
module fpu_exc_chk (
	// clock and reset
	input wire sys_clk,
	input wire rst_b,
	// register port and op event
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire op_done,
	input wire op_sig_nan,
	input wire op_unsupported,
	input wire op_indeterminate,
	input wire op_stack_fault,
	input wire op_min_exp,
	input wire op_split_exp_zero,
	// results and pins
	input wire [2:0] default_result,
	input wire stall_result,
	input wire output_status_enable,
	input wire coproc_select_high,
	input wire data_bus_pins_oe,
	input wire fault_signal_n_o,
	input wire fault_signal_n_oe
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	a_stall_to_fault: assert property (stall_result |-> ##[0:2] !fault_signal_n_o)
		else $error("unmasked exception left fault high");
	a_stall_cause: assert property (stall_result |-> $past(op_done))
		else $error("stall without an op");
	a_init_release: assert property (reg_wr && reg_addr == 4'h5
		&& reg_wdata[3:0] == 4'h1 && !op_done |-> ##[1:3] fault_signal_n_o)
		else $error("init did not release fault");
	a_fault_held: assert property (!fault_signal_n_o && !reg_wr
		&& !$past(reg_wr) |=> !fault_signal_n_o)
		else $error("fault dropped without a command");
	a_float_no_en: assert property (!output_status_enable [*3]
		|=> !fault_signal_n_oe && !data_bus_pins_oe)
		else $error("output driven without enable");
	a_float_no_sel: assert property (!coproc_select_high [*3]
		|=> !data_bus_pins_oe)
		else $error("data driven while unselected");
	a_oe_pair: assert property (data_bus_pins_oe |-> fault_signal_n_oe)
		else $error("data driven without enable");
	a_split_zero: assert property (op_done && op_split_exp_zero && !op_sig_nan
		&& !op_unsupported && !op_indeterminate && !op_stack_fault
		&& !op_min_exp |=> default_result == 3'h5)
		else $error("split of zero gave wrong result");
endmodule // fpu_exc_chk
bind fpu_exception_unit fpu_exc_chk chk_inst (.*);

// >>> verif/host_cpu_model.sv
// host side: vector 16 on escape or wait while fault pin is low
module host_cpu_model (
	// clock and reset
	input wire sys_clk,
	input wire rst_b,
	// handshake
	input wire fault_pin_n,
	input wire esc_or_wait,
	output logic [7:0] vector_r
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			vector_r <= 8'h00;
		else if (esc_or_wait)
			vector_r <= fault_pin_n ? 8'h00 : 8'h10;
	end
endmodule // host_cpu_model

// >>> verif/fpu_exception_unit_bench.sv
// register-level tests of the exception unit
module fpu_exception_unit_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, op_done = 0, coprocessor_escape_opcode = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, op_ip = 32'h0, op_dp = 32'h0000BEEF;
	logic [31:0] data_out_val = 32'hA5C30F96, reg_rdata, data_bus_pins_o;
	logic [16:0] q = 17'h0;
	logic ose = 0, sel_n = 1, sel = 0, bus_read = 0;
	logic [2:0] default_result;
	logic round_to_inf, stall_result, data_bus_pins_oe, fault_o, fault_oe;
	logic [7:0] vector_r;
	wire fault_wire = fault_oe ? fault_o : 1'b1;
	int n_errors = 0, comparisons = 0;
	fpu_exception_unit fpu_exception_unit_inst (.sys_clk(sys_clk),
		.rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.op_done(op_done), .op_sig_nan(q[0]), .op_quiet_nan(q[1]),
		.op_qnan_traps(q[2]), .op_unsupported(q[3]),
		.op_indeterminate(q[4]), .op_stack_fault(q[5]), .op_min_exp(q[6]),
		.op_sig_nonzero(q[7]), .op_ext_load(q[8]), .op_divide(q[9]),
		.op_divisor_zero(q[10]), .op_dividend_finite_nz(q[11]),
		.op_split_exp_zero(q[12]), .op_overflow(q[13]), .op_tiny(q[14]),
		.op_acc_loss(q[15]), .op_not_exact(q[16]), .op_ip(op_ip),
		.op_dp(op_dp), .op_has_mem(1'b1), .default_result(default_result),
		.round_to_inf(round_to_inf), .stall_result(stall_result),
		.output_status_enable(ose), .coproc_select_low_n(sel_n),
		.coproc_select_high(sel), .bus_read(bus_read),
		.data_out_val(data_out_val), .data_bus_pins_o(data_bus_pins_o),
		.data_bus_pins_oe(data_bus_pins_oe), .fault_signal_n_o(fault_o),
		.fault_signal_n_oe(fault_oe));
	host_cpu_model host_cpu_model_inst (.sys_clk(sys_clk), .rst_b(rst_b),
		.fault_pin_n(fault_wire), .esc_or_wait(coprocessor_escape_opcode), .vector_r(vector_r));
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	task cmp(input string n, input [31:0] e, input [31:0] s);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task rd(input [3:0] a, input [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 cmp("reg_rdata", e, reg_rdata);
		@(posedge sys_clk);
	endtask
	task op(input [16:0] v, input [4:0] dr);
		q <= v;
		op_ip <= op_ip + 32'h10;
		op_done <= 1'b1;
		@(posedge sys_clk);
		op_done <= 1'b0;
		#1 cmp("stall_round_result", {27'h0, dr},
			{27'h0, stall_result, round_to_inf, default_result});
		@(posedge sys_clk);
	endtask
	task host(input [7:0] e);
		coprocessor_escape_opcode <= 1'b1;
		@(posedge sys_clk);
		coprocessor_escape_opcode <= 1'b0;
		#1 cmp("vector", {24'h0, e}, {24'h0, vector_r});
		@(posedge sys_clk);
	endtask
	task settle(input [31:0] e, input [31:0] s);
		repeat (4) @(posedge sys_clk);
	endtask
	task finish_test;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#(3000 * 50);
		n_errors++;
		finish_test;
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		cmp("fault_oe", 32'h0, {31'h0, fault_oe});
		cmp("fault_o", 32'h0, {31'h0, fault_o});
		rd(4'h1, 32'h81);
		rd(4'h0, 32'h037E);
		{ose, sel_n, sel, bus_read} <= 4'h B;
		repeat (4) @(posedge sys_clk);
		cmp("pins", data_out_val, data_bus_pins_o);
		cmp("pins_oe", 32'h1, {31'h0, data_bus_pins_oe});
		host(8'h10);
		wr(4'h5, 32'h1);
		rd(4'h0, 32'h037F);
		rd(4'h1, 32'h0);
		host(8'h00);
		wr(4'h5, 32'h1003);
		rd(4'h0, 32'h1003);
		op(17'h1E000, 5'h1B);
		rd(4'h1, 32'h88);
		cmp("fault", 32'h0, {31'h0, fault_wire});
		rd(4'h3, op_ip);
		rd(4'h4, op_dp);
		wr(4'h5, 32'h2);
		cmp("fault", 32'h1, {31'h0, fault_wire});
		wr(4'h5, 32'h33);
		op(17'h00021, 5'h01);
		rd(4'h1, 32'h41);
		op(17'h01000, 5'h15);
		rd(4'h1, 32'hC5);
		wr(4'h5, 32'h1);
		op(17'h001C0, 5'h00);
		rd(4'h1, 32'h0);
		op(17'h000C0, 5'h00);
		rd(4'h1, 32'h02);
		op(17'h04000, 5'h00);
		rd(4'h1, 32'h02);
		op(17'h0C000, 5'h04);
		rd(4'h1, 32'h12);
		op(17'h10000, 5'h00);
		rd(4'h1, 32'h32);
		op(17'h00008, 5'h01);
		rd(4'h1, 32'h33);
		op(17'h00E00, 5'h02);
		rd(4'h1, 32'h37);
		wr(4'h2, 32'h0004);
		wr(4'h5, 32'h00050004);
		rd(4'h2, 32'h0007);
		sel <= 1'b0;
		repeat (4) @(posedge sys_clk);
		cmp("pins_oe", 32'h0, {31'h0, data_bus_pins_oe});
		ose <= 1'b0;
		repeat (4) @(posedge sys_clk);
		cmp("fault_oe", 32'h0, {31'h0, fault_oe});
		finish_test;
	end
endmodule // fpu_exception_unit_bench
